// ===== inc/cpfs_defines.svh
`ifndef CPFS_DEFINES_SVH
`define CPFS_DEFINES_SVH

// Pin group size and option field width
`define CPFS_NPINS 10
`define CPFS_OPT_W 4

// Pin function option codes
`define CPFS_OPT_LDRV 4'h0
`define CPFS_OPT_POWER_ENABLE_N 4'h1
`define CPFS_OPT_TX_ACTIVITY_LED_N 4'h2
`define CPFS_OPT_RX_ACTIVITY_LED_N 4'h3
`define CPFS_OPT_TRAFFIC 4'h4
`define CPFS_OPT_SLEEP 4'h5
`define CPFS_OPT_CLK_HALF 4'h6
`define CPFS_OPT_CLK_QUARTER 4'h7
`define CPFS_OPT_CLK_EIGHTH 4'h8
`define CPFS_OPT_PULL_UP 4'h9
`define CPFS_OPT_DRIVE1 4'hA
`define CPFS_OPT_DRIVE0 4'hB
`define CPFS_OPT_BITBANG 4'hC
`define CPFS_OPT_PULL_DOWN 4'hD

// Pin that defaults to pulled-down input
`define CPFS_PULLDOWN_PIN 7
// Pins that may carry clocks or a fixed high level
`define CPFS_CLK_PIN_MASK 10'h361
// Pins that may be handed to bit-bang I/O
`define CPFS_BB_PIN_MASK 10'h360
// Pins that may carry the general status functions
`define CPFS_GEN_PIN_MASK 10'h37F

// Divider exponents for the clock outputs
`define CPFS_HALF_LOG2 1
`define CPFS_QUARTER_LOG2 2
`define CPFS_EIGHTH_LOG2 3

// Timing
`define CPFS_SYS_CLK_KHZ 10000
`define CPFS_LED_HOLD_NS 1000
`define CPFS_LED_HOLD_CYC \
    ((`CPFS_LED_HOLD_NS * `CPFS_SYS_CLK_KHZ + 999999) / 1000000)

// Reset values
`define CPFS_RST_INACTIVE_N 1'b1
`define CPFS_RST_LOW 1'b0

`endif

// ===== inc/cpfs_pkg.sv
`include "cpfs_defines.svh"

package cpfs_pkg;

    typedef enum logic [`CPFS_OPT_W-1:0] {
        CPFS_LDRV = `CPFS_OPT_LDRV,
        CPFS_POWER_ENABLE_N = `CPFS_OPT_POWER_ENABLE_N,
        CPFS_TX_ACTIVITY_LED_N = `CPFS_OPT_TX_ACTIVITY_LED_N,
        CPFS_RX_ACTIVITY_LED_N = `CPFS_OPT_RX_ACTIVITY_LED_N,
        CPFS_TRAFFIC = `CPFS_OPT_TRAFFIC,
        CPFS_SLEEP = `CPFS_OPT_SLEEP,
        CPFS_CLK_HALF = `CPFS_OPT_CLK_HALF,
        CPFS_CLK_QUARTER = `CPFS_OPT_CLK_QUARTER,
        CPFS_CLK_EIGHTH = `CPFS_OPT_CLK_EIGHTH,
        CPFS_PULL_UP = `CPFS_OPT_PULL_UP,
        CPFS_DRIVE1 = `CPFS_OPT_DRIVE1,
        CPFS_DRIVE0 = `CPFS_OPT_DRIVE0,
        CPFS_BITBANG = `CPFS_OPT_BITBANG,
        CPFS_PULL_DOWN = `CPFS_OPT_PULL_DOWN
    } cpfs_opt_t;

    typedef enum {
        LDRV_IDLE,
        LDRV_LEAD,
        LDRV_GRANT,
        LDRV_SEND
    } cpfs_ldrv_state_t;

endpackage

// ===== inc/cpfs_fn_if.sv
`timescale 1ns/1ns

// Function signals shared by every pin cell
interface cpfs_fn_if;
    logic line_driver_enable;
    logic power_enable_n;
    logic tx_activity_led_n;
    logic rx_activity_led_n;
    logic traffic_led_n;
    logic sleep_n;
    logic half_rate_clock_out;
    logic quarter_rate_clock_out;
    logic eighth_rate_clock_out;

    modport src (
        output line_driver_enable,
        output power_enable_n,
        output tx_activity_led_n,
        output rx_activity_led_n,
        output traffic_led_n,
        output sleep_n,
        output half_rate_clock_out,
        output quarter_rate_clock_out,
        output eighth_rate_clock_out
    );

    modport sink (
        input line_driver_enable,
        input power_enable_n,
        input tx_activity_led_n,
        input rx_activity_led_n,
        input traffic_led_n,
        input sleep_n,
        input half_rate_clock_out,
        input quarter_rate_clock_out,
        input eighth_rate_clock_out
    );
endinterface

// ===== hw/cpfs_clkdiv.sv
`timescale 1ns/1ns
`include "cpfs_defines.svh"

// Square-wave divider by 2**DIV_LOG2, held low and reset while stopped
module cpfs_clkdiv #(
    parameter int DIV_LOG2 = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic stop,
    output logic clk_out
);
    logic [DIV_LOG2-1:0] cnt;

    // Counter restarts from zero so the first edge after resume is clean
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= '0;
        end else if (stop) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    // Counter top bit through a flop: period 2**DIV_LOG2, no decode glitch
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clk_out <= `CPFS_RST_LOW;
        end else if (stop) begin
            clk_out <= `CPFS_RST_LOW;
        end else begin
            clk_out <= cnt[DIV_LOG2-1];
        end
    end

    property p_stopped_low;
        @(posedge clk) disable iff (rst)
        stop |=> !clk_out;
    endproperty
    a_stopped_low: assert property (p_stopped_low)
        else $error("divided clock runs while stopped");
endmodule

// ===== hw/cpfs_pin_cell.sv
`timescale 1ns/1ns
`include "cpfs_defines.svh"

// One configurable pin: option decode and registered pin drive
module cpfs_pin_cell #(
    parameter bit CLK_OK = 1'b1,
    parameter bit BB_OK = 1'b1,
    parameter bit GEN_OK = 1'b1,
    parameter cpfs_pkg::cpfs_opt_t FALLBACK = cpfs_pkg::CPFS_PULL_UP
) (
    input wire logic clk,
    input wire logic rst,
    cpfs_fn_if.sink fn,
    input wire logic [`CPFS_OPT_W-1:0] option,
    input wire logic bb_out,
    input wire logic bb_oe,
    output logic pin_out,
    output logic pin_oe_n,
    output logic pull_up,
    output logic pull_down
);
    logic next_out;
    logic next_drive;
    logic next_pu;
    logic next_pd;
    logic [`CPFS_OPT_W-1:0] eff;

    // Options this pin cannot carry fall back to its default input
    always_comb begin
        eff = option;
        case (option)
            `CPFS_OPT_CLK_HALF, `CPFS_OPT_CLK_QUARTER,
            `CPFS_OPT_CLK_EIGHTH, `CPFS_OPT_DRIVE1: begin
                if (!CLK_OK) eff = FALLBACK;
            end
            `CPFS_OPT_BITBANG: begin
                if (!BB_OK) eff = FALLBACK;
            end
            `CPFS_OPT_PULL_UP, `CPFS_OPT_PULL_DOWN: begin
                eff = option;
            end
            default: begin
                if (!GEN_OK) eff = FALLBACK;
            end
        endcase
    end

    // Function select
    always_comb begin
        next_out = 1'b0;
        next_drive = 1'b1;
        next_pu = 1'b0;
        next_pd = 1'b0;
        case (eff)
            `CPFS_OPT_LDRV: next_out = fn.line_driver_enable;
            `CPFS_OPT_POWER_ENABLE_N: next_out = fn.power_enable_n;
            `CPFS_OPT_TX_ACTIVITY_LED_N: next_out = fn.tx_activity_led_n;
            `CPFS_OPT_RX_ACTIVITY_LED_N: next_out = fn.rx_activity_led_n;
            `CPFS_OPT_TRAFFIC: next_out = fn.traffic_led_n;
            `CPFS_OPT_SLEEP: next_out = fn.sleep_n;
            `CPFS_OPT_CLK_HALF: next_out = fn.half_rate_clock_out;
            `CPFS_OPT_CLK_QUARTER: next_out = fn.quarter_rate_clock_out;
            `CPFS_OPT_CLK_EIGHTH: next_out = fn.eighth_rate_clock_out;
            `CPFS_OPT_DRIVE1: next_out = 1'b1;
            `CPFS_OPT_DRIVE0: next_out = 1'b0;
            `CPFS_OPT_BITBANG: begin
                next_out = bb_out;
                next_drive = bb_oe;
            end
            `CPFS_OPT_PULL_DOWN: begin
                next_drive = 1'b0;
                next_pd = 1'b1;
            end
            default: begin
                next_drive = 1'b0;
                next_pu = 1'b1;
            end
        endcase
    end

    // Pin drive from flops; reset leaves the pin as a pulled-up input
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_out <= `CPFS_RST_LOW;
            pin_oe_n <= `CPFS_RST_INACTIVE_N;
            pull_up <= 1'b1;
            pull_down <= `CPFS_RST_LOW;
        end else begin
            pin_out <= next_out;
            pin_oe_n <= ~next_drive;
            pull_up <= next_pu;
            pull_down <= next_pd;
        end
    end

    // Checked on the decoded option, so refused codes do not trip it
    property p_drive0;
        @(posedge clk) disable iff (rst)
        eff == `CPFS_OPT_DRIVE0 |=> !pin_out && !pin_oe_n;
    endproperty
    a_drive0: assert property (p_drive0)
        else $error("fixed low option not driven low");
endmodule

// ===== hw/cpfs_top.sv
`timescale 1ns/1ns
`include "cpfs_defines.svh"

module cpfs_top #(
    parameter int NPINS = `CPFS_NPINS,
    parameter int LED_HOLD = `CPFS_LED_HOLD_CYC
) (
    input wire logic SYS_CLK,
    input wire logic RESET,
    // Configuration source
    input wire logic EEPROM_PRESENT,
    input wire logic CFG_LOAD,
    input wire logic [NPINS*`CPFS_OPT_W-1:0] CFG_PIN_OPTION,
    input wire logic REMOTE_WAKE_EN,
    // USB state
    input wire logic USB_CONFIGURED,
    input wire logic USB_SUSPEND,
    output logic USB_RESUME_REQ,
    // Serial engine side
    input wire logic UART_TXD,
    input wire logic UART_TX_PENDING,
    input wire logic UART_TX_ACTIVE,
    input wire logic UART_RX_ACTIVE,
    input wire logic [15:0] BIT_PERIOD_CYCLES,
    output logic UART_TX_START,
    output logic UART_RXD,
    input wire logic UART_RTS,
    output logic UART_CTS,
    input wire logic UART_DTR,
    output logic UART_DSR,
    output logic UART_DCD,
    output logic UART_RI,
    // Serial pins
    output logic TXD_PIN,
    input wire logic RXD_PIN,
    output logic RTS_N_PIN,
    input wire logic CTS_N_PIN,
    output logic DTR_N_PIN,
    input wire logic DSR_N_PIN,
    input wire logic DCD_N_PIN,
    input wire logic RING_INDICATOR_N_PIN,
    // Software bit-bang I/O
    input wire logic [NPINS-1:0] BITBANG_OUT,
    input wire logic [NPINS-1:0] BITBANG_OE,
    output logic [NPINS-1:0] BITBANG_IN,
    // Configurable pin group
    input wire logic [NPINS-1:0] CONFIG_PIN_GROUP_IN,
    output logic [NPINS-1:0] CONFIG_PIN_GROUP_OUT,
    output logic [NPINS-1:0] CONFIG_PIN_GROUP_OE_N,
    output logic [NPINS-1:0] CONFIG_PIN_GROUP_PULL_UP,
    output logic [NPINS-1:0] CONFIG_PIN_GROUP_PULL_DOWN
);
    localparam int SW = 5;

    cpfs_fn_if fn ();

    logic [`CPFS_OPT_W-1:0] opt [NPINS];
    cpfs_pkg::cpfs_ldrv_state_t state;
    logic [15:0] lead_cnt;
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    logic [NPINS-1:0] pin_s1;
    logic ri_prev;
    logic [15:0] tx_hold;
    logic [15:0] rx_hold;

    // Option store: EEPROM contents or the no-EEPROM defaults
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            for (int i = 0; i < NPINS; i++) begin
                opt[i] <= (i == `CPFS_PULLDOWN_PIN) ?
                    `CPFS_OPT_PULL_DOWN : `CPFS_OPT_PULL_UP;
            end
        end else if (CFG_LOAD) begin
            for (int i = 0; i < NPINS; i++) begin
                if (EEPROM_PRESENT) begin
                    opt[i] <= CFG_PIN_OPTION[i*`CPFS_OPT_W +:
                        `CPFS_OPT_W];
                end else if (i == `CPFS_PULLDOWN_PIN) begin
                    opt[i] <= `CPFS_OPT_PULL_DOWN;
                end else begin
                    opt[i] <= `CPFS_OPT_PULL_UP;
                end
            end
        end
    end

    // Line-driver enable sequencer; engine waits for the start grant
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            state <= cpfs_pkg::LDRV_IDLE;
            lead_cnt <= '0;
        end else begin
            case (state)
                cpfs_pkg::LDRV_IDLE: begin
                    lead_cnt <= 16'h0001;
                    if (UART_TX_PENDING) begin
                        state <= cpfs_pkg::LDRV_LEAD;
                    end
                end
                cpfs_pkg::LDRV_LEAD: begin
                    // Zero period still gives one cycle of lead
                    if (lead_cnt >= BIT_PERIOD_CYCLES) begin
                        state <= cpfs_pkg::LDRV_GRANT;
                    end else begin
                        lead_cnt <= lead_cnt + 16'h0001;
                    end
                end
                cpfs_pkg::LDRV_GRANT: begin
                    if (UART_TX_ACTIVE) begin
                        state <= cpfs_pkg::LDRV_SEND;
                    end
                end
                cpfs_pkg::LDRV_SEND: begin
                    // Frame end includes the stop bit
                    if (!UART_TX_ACTIVE) begin
                        state <= cpfs_pkg::LDRV_IDLE;
                    end
                end
                default: state <= cpfs_pkg::LDRV_IDLE;
            endcase
        end
    end

    assign UART_TX_START = (state == cpfs_pkg::LDRV_GRANT);
    assign fn.line_driver_enable = (state != cpfs_pkg::LDRV_IDLE);

    // Power and suspend indicators
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            fn.power_enable_n <= `CPFS_RST_INACTIVE_N;
            fn.sleep_n <= `CPFS_RST_INACTIVE_N;
        end else begin
            fn.power_enable_n <= USB_SUSPEND | ~USB_CONFIGURED;
            fn.sleep_n <= ~USB_SUSPEND;
        end
    end

    // Stretch activity so short bursts still light the LED
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            tx_hold <= '0;
            rx_hold <= '0;
        end else begin
            if (UART_TX_ACTIVE) begin
                tx_hold <= 16'(LED_HOLD);
            end else if (tx_hold != '0) begin
                tx_hold <= tx_hold - 16'h0001;
            end
            if (UART_RX_ACTIVE) begin
                rx_hold <= 16'(LED_HOLD);
            end else if (rx_hold != '0) begin
                rx_hold <= rx_hold - 16'h0001;
            end
        end
    end

    assign fn.tx_activity_led_n = (tx_hold == '0);
    assign fn.rx_activity_led_n = (rx_hold == '0);
    assign fn.traffic_led_n = fn.tx_activity_led_n &
        fn.rx_activity_led_n;

    // Divided clocks, all halted in suspend
    cpfs_clkdiv #(.DIV_LOG2(`CPFS_HALF_LOG2)) u_half (
        .clk(SYS_CLK),
        .rst(RESET),
        .stop(USB_SUSPEND),
        .clk_out(fn.half_rate_clock_out)
    );
    cpfs_clkdiv #(.DIV_LOG2(`CPFS_QUARTER_LOG2)) u_quarter (
        .clk(SYS_CLK),
        .rst(RESET),
        .stop(USB_SUSPEND),
        .clk_out(fn.quarter_rate_clock_out)
    );
    cpfs_clkdiv #(.DIV_LOG2(`CPFS_EIGHTH_LOG2)) u_eighth (
        .clk(SYS_CLK),
        .rst(RESET),
        .stop(USB_SUSPEND),
        .clk_out(fn.eighth_rate_clock_out)
    );

    // Pin cells
    for (genvar g = 0; g < NPINS; g++) begin : g_pin
        localparam bit CLK_OK = 1'(`CPFS_CLK_PIN_MASK >> g);
        localparam bit BB_OK = 1'(`CPFS_BB_PIN_MASK >> g);
        localparam bit GEN_OK = 1'(`CPFS_GEN_PIN_MASK >> g);
        cpfs_pin_cell #(
            .CLK_OK(CLK_OK),
            .BB_OK(BB_OK),
            .GEN_OK(GEN_OK),
            .FALLBACK((g == `CPFS_PULLDOWN_PIN) ?
                cpfs_pkg::CPFS_PULL_DOWN : cpfs_pkg::CPFS_PULL_UP)
        ) u_cell (
            .clk(SYS_CLK),
            .rst(RESET),
            .fn(fn),
            .option(opt[g]),
            .bb_out(BITBANG_OUT[g]),
            .bb_oe(BITBANG_OE[g]),
            .pin_out(CONFIG_PIN_GROUP_OUT[g]),
            .pin_oe_n(CONFIG_PIN_GROUP_OE_N[g]),
            .pull_up(CONFIG_PIN_GROUP_PULL_UP[g]),
            .pull_down(CONFIG_PIN_GROUP_PULL_DOWN[g])
        );
    end

    // Two-flop synchronisers on every pin input
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            sync1 <= '1;
            sync2 <= '1;
            pin_s1 <= '0;
            BITBANG_IN <= '0;
        end else begin
            sync1 <= {RING_INDICATOR_N_PIN, DCD_N_PIN, DSR_N_PIN,
                CTS_N_PIN, RXD_PIN};
            sync2 <= sync1;
            pin_s1 <= CONFIG_PIN_GROUP_IN;
            BITBANG_IN <= pin_s1;
        end
    end

    // Default UART mapping; active-low pins inverted here
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            TXD_PIN <= 1'b1;
            RTS_N_PIN <= `CPFS_RST_INACTIVE_N;
            DTR_N_PIN <= `CPFS_RST_INACTIVE_N;
            UART_RXD <= 1'b1;
            UART_CTS <= `CPFS_RST_LOW;
            UART_DSR <= `CPFS_RST_LOW;
            UART_DCD <= `CPFS_RST_LOW;
            UART_RI <= `CPFS_RST_LOW;
        end else begin
            TXD_PIN <= UART_TXD;
            UART_RXD <= sync2[0];
            RTS_N_PIN <= ~UART_RTS;
            UART_CTS <= ~sync2[1];
            DTR_N_PIN <= ~UART_DTR;
            UART_DSR <= ~sync2[2];
            UART_DCD <= ~sync2[3];
            UART_RI <= ~sync2[4];
        end
    end

    // Ring falling edge wakes the host only when allowed and suspended
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            ri_prev <= 1'b1;
            USB_RESUME_REQ <= `CPFS_RST_LOW;
        end else begin
            ri_prev <= sync2[4];
            USB_RESUME_REQ <= REMOTE_WAKE_EN & USB_SUSPEND &
                ri_prev & ~sync2[4];
        end
    end

    property p_eeprom_load;
        @(posedge SYS_CLK) disable iff (RESET)
        CFG_LOAD && EEPROM_PRESENT |=>
            opt[0] == $past(CFG_PIN_OPTION[`CPFS_OPT_W-1:0]);
    endproperty
    a_eeprom_load: assert property (p_eeprom_load)
        else $error("stored option not taken");

    property p_defaults;
        @(posedge SYS_CLK) disable iff (RESET)
        CFG_LOAD && !EEPROM_PRESENT |=>
            opt[`CPFS_PULLDOWN_PIN] == `CPFS_OPT_PULL_DOWN &&
            opt[0] == `CPFS_OPT_PULL_UP;
    endproperty
    a_defaults: assert property (p_defaults)
        else $error("default options wrong");

    property p_lead;
        @(posedge SYS_CLK) disable iff (RESET)
        $rose(UART_TX_START) |-> $past(fn.line_driver_enable) &&
            $past(lead_cnt) >= BIT_PERIOD_CYCLES;
    endproperty
    a_lead: assert property (p_lead)
        else $error("start granted without a full bit of lead");

    property p_frame_covered;
        @(posedge SYS_CLK) disable iff (RESET)
        state == cpfs_pkg::LDRV_SEND && UART_TX_ACTIVE |=>
            fn.line_driver_enable;
    endproperty
    a_frame_covered: assert property (p_frame_covered)
        else $error("driver enable dropped inside a frame");

    property p_power_enable_n;
        @(posedge SYS_CLK) disable iff (RESET)
        USB_CONFIGURED && !USB_SUSPEND ##1 USB_SUSPEND |=>
            !$past(fn.power_enable_n) && fn.power_enable_n;
    endproperty
    a_power_enable_n: assert property (p_power_enable_n)
        else $error("power enable did not follow suspend");

    property p_tx_activity_led_n;
        @(posedge SYS_CLK) disable iff (RESET)
        UART_TX_ACTIVE |=> !fn.tx_activity_led_n && !fn.traffic_led_n;
    endproperty
    a_tx_activity_led_n: assert property (p_tx_activity_led_n)
        else $error("transmit LED not low");

    property p_rx_activity_led_n;
        @(posedge SYS_CLK) disable iff (RESET)
        UART_RX_ACTIVE |=> !fn.rx_activity_led_n;
    endproperty
    a_rx_activity_led_n: assert property (p_rx_activity_led_n)
        else $error("receive LED not low");

    property p_traffic;
        @(posedge SYS_CLK) disable iff (RESET)
        fn.traffic_led_n == (fn.tx_activity_led_n && fn.rx_activity_led_n);
    endproperty
    a_traffic: assert property (p_traffic)
        else $error("traffic LED mismatch");

    property p_sleep;
        @(posedge SYS_CLK) disable iff (RESET)
        USB_SUSPEND [*2] |-> !fn.sleep_n;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("suspend indicator high in suspend");

    property p_clk_stop;
        @(posedge SYS_CLK) disable iff (RESET)
        USB_SUSPEND |=> !fn.half_rate_clock_out &&
            !fn.quarter_rate_clock_out && !fn.eighth_rate_clock_out;
    endproperty
    a_clk_stop: assert property (p_clk_stop)
        else $error("clock output running in suspend");

    property p_txd;
        @(posedge SYS_CLK) disable iff (RESET)
        ##1 TXD_PIN == $past(UART_TXD);
    endproperty
    a_txd: assert property (p_txd)
        else $error("transmit pin does not follow serial data");

    property p_cts;
        @(posedge SYS_CLK) disable iff (RESET)
        !CTS_N_PIN [*4] |-> UART_CTS;
    endproperty
    a_cts: assert property (p_cts)
        else $error("clear-to-send not seen");

    property p_wake;
        @(posedge SYS_CLK) disable iff (RESET)
        USB_RESUME_REQ |-> $past(REMOTE_WAKE_EN) && $past(USB_SUSPEND);
    endproperty
    a_wake: assert property (p_wake)
        else $error("resume requested without wake enable");

    c_frame: cover property (@(posedge SYS_CLK) disable iff (RESET)
        $fell(UART_TX_ACTIVE) && state == cpfs_pkg::LDRV_SEND);
    c_wake: cover property (@(posedge SYS_CLK) disable iff (RESET)
        USB_RESUME_REQ);
    c_load: cover property (@(posedge SYS_CLK) disable iff (RESET)
        CFG_LOAD && EEPROM_PRESENT);
endmodule

// ===== test/cpfs_far_model.sv
`timescale 1ns/1ns
// Loopback connector and pin loads on the far side
module cpfs_far_model (
    input wire logic txd,
    input wire logic rts_n,
    input wire logic dtr_n,
    input wire logic [9:0] pin_out,
    input wire logic [9:0] oe_n,
    input wire logic [9:0] pu,
    input wire logic [9:0] pd,
    output logic rxd,
    output logic cts_n,
    output logic dsr_n,
    output logic [9:0] level
);
    // Handshake lines echo back, as a loopback plug does
    assign rxd = txd;
    assign cts_n = rts_n;
    assign dsr_n = dtr_n;
    // Released pins go to the pull; unpulled ones flip
    always_comb begin
        for (int i = 0; i < 10; i++) begin
            level[i] = !oe_n[i] ? pin_out[i] : pu[i] ? 1'b1 :
                pd[i] ? 1'b0 : ~pin_out[i];
        end
    end
endmodule

// ===== test/tb.sv
`timescale 1ns/1ns
module tb;
    logic SYS_CLK = 0, RESET = 1, EEPROM_PRESENT = 0, CFG_LOAD = 0;
    logic REMOTE_WAKE_EN = 0, USB_CONFIGURED = 0, USB_SUSPEND = 0;
    logic UART_TXD = 1, UART_TX_PENDING = 0, UART_TX_ACTIVE = 0;
    logic UART_RX_ACTIVE = 0, UART_RTS = 0, UART_DTR = 0;
    logic DCD_N_PIN = 1, RING_INDICATOR_N_PIN = 1;
    logic [39:0] CFG_PIN_OPTION = 40'h0;
    logic [15:0] BIT_PERIOD_CYCLES = 16'h0003;
    logic [9:0] BITBANG_OUT = 10'h3FF, BITBANG_OE = 10'h3FF;
    logic [9:0] CONFIG_PIN_GROUP_IN, BITBANG_IN, CONFIG_PIN_GROUP_OUT;
    logic [9:0] CONFIG_PIN_GROUP_OE_N, CONFIG_PIN_GROUP_PULL_UP;
    logic [9:0] CONFIG_PIN_GROUP_PULL_DOWN;
    logic USB_RESUME_REQ, UART_TX_START, UART_RXD, UART_CTS, UART_DSR;
    logic UART_DCD, UART_RI, TXD_PIN, RXD_PIN, RTS_N_PIN, CTS_N_PIN;
    logic DTR_N_PIN, DSR_N_PIN, a;
    int err_count = 0, tests_run = 0, cyc = 0, n;
    // Short LED hold keeps the run brief
    cpfs_top #(.LED_HOLD(2)) i_dut (.*);
    cpfs_far_model i_far (.txd(TXD_PIN), .rts_n(RTS_N_PIN),
        .dtr_n(DTR_N_PIN), .pin_out(CONFIG_PIN_GROUP_OUT),
        .oe_n(CONFIG_PIN_GROUP_OE_N), .pu(CONFIG_PIN_GROUP_PULL_UP),
        .pd(CONFIG_PIN_GROUP_PULL_DOWN), .rxd(RXD_PIN), .cts_n(CTS_N_PIN),
        .dsr_n(DSR_N_PIN), .level(CONFIG_PIN_GROUP_IN));
    // Clock and hang guard
    initial forever #50 SYS_CLK = ~SYS_CLK;
    always @(posedge SYS_CLK) if (++cyc == 3000) begin
        err_count++;
        summarize();
    end
    task step(input int k);
        repeat (k) @(posedge SYS_CLK);
        #10;
    endtask
    task chk(input string what, input logic [9:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Pulse the load; pin outputs settle two edges on
    task load(input logic p, input logic [39:0] o);
        EEPROM_PRESENT = p;
        CFG_PIN_OPTION = o;
        CFG_LOAD = 1;
        step(1);
        CFG_LOAD = 0;
        step(2);
    endtask
    task t_defaults;
        load(0, 40'h02A6C4153A);
        chk("pu", CONFIG_PIN_GROUP_PULL_UP, 10'h37F);
        chk("pd", CONFIG_PIN_GROUP_PULL_DOWN, 10'h080);
        chk("oe", CONFIG_PIN_GROUP_OE_N, 10'h3FF);
        $display("defaults done");
    endtask
    // Pin 7 asks for a high level it may not carry
    task t_options;
        USB_CONFIGURED = 1;
        load(1, 40'h02A6C4153A);
        chk("out", CONFIG_PIN_GROUP_OUT & 10'h33F, 10'h137);
        chk("oe", CONFIG_PIN_GROUP_OE_N, 10'h080);
        chk("pd", CONFIG_PIN_GROUP_PULL_DOWN, 10'h080);
        chk("bbin", BITBANG_IN & 10'h081, 10'h001);
        BITBANG_OUT = 10'h000;
        step(2);
        chk("bb", CONFIG_PIN_GROUP_OUT & 10'h020, 10'h000);
        a = CONFIG_PIN_GROUP_OUT[6];
        step(1);
        chk("clk", {9'h0, CONFIG_PIN_GROUP_OUT[6]}, {9'h0, ~a});
        USB_SUSPEND = 1;
        step(2);
        chk("susp", CONFIG_PIN_GROUP_OUT & 10'h04C, 10'h008);
        step(3);
        chk("clk", CONFIG_PIN_GROUP_OUT & 10'h040, 10'h000);
        USB_SUSPEND = 0;
        $display("options done");
    endtask
    // Enable must lead the start bit by exactly one bit time
    task t_tx;
        UART_TX_PENDING = 1;
        for (n = 0; CONFIG_PIN_GROUP_OUT[9] !== 1'b1 && n < 30; n++) step(1);
        for (n = 1; UART_TX_START !== 1'b1 && n < 30; n++) step(1);
        UART_TX_PENDING = 0;
        UART_TX_ACTIVE = 1;
        UART_TXD = 0;
        step(4);
        chk("lead", n[9:0], 10'h003);
        chk("txd", {9'h0, TXD_PIN}, 10'h000);
        chk("rxd", {9'h0, UART_RXD}, 10'h000);
        chk("led", CONFIG_PIN_GROUP_OUT & 10'h310, 10'h200);
        UART_TX_ACTIVE = 0;
        UART_TXD = 1;
        step(2);
        chk("den", CONFIG_PIN_GROUP_OUT & 10'h200, 10'h000);
        UART_RX_ACTIVE = 1;
        step(3);
        chk("rled", CONFIG_PIN_GROUP_OUT & 10'h012, 10'h000);
        UART_RX_ACTIVE = 0;
        step(8);
        chk("off", CONFIG_PIN_GROUP_OUT & 10'h112, 10'h112);
        $display("transfer done");
    endtask
    task t_serial;
        UART_RTS = 1;
        UART_DTR = 1;
        DCD_N_PIN = 0;
        step(5);
        chk("hs", {5'h00, RTS_N_PIN, DTR_N_PIN, UART_CTS, UART_DSR, UART_DCD},
            10'h007);
        $display("serial done");
    endtask
    // Ring falls while suspended with wake enabled
    task t_wake;
        REMOTE_WAKE_EN = 1;
        USB_SUSPEND = 1;
        RING_INDICATOR_N_PIN = 0;
        for (n = 0; USB_RESUME_REQ !== 1'b1 && n < 10; n++) step(1);
        chk("wake", n[9:0], 10'h003);
        chk("ri", {9'h0, UART_RI}, 10'h001);
        step(1);
        chk("pulse", {9'h0, USB_RESUME_REQ}, 10'h000);
        $display("wake done");
    endtask
    // Quarter rate on pin 0, eighth rate on pin 5, fixed low on pin 1
    task t_clocks;
        logic [7:0] q, e;
        USB_SUSPEND = 0;
        load(1, 40'h00008000B7);
        chk("drv0", (CONFIG_PIN_GROUP_OUT | CONFIG_PIN_GROUP_OE_N) & 10'h002,
            10'h000);
        for (n = 0; n < 8; n++) begin
            q[n] = CONFIG_PIN_GROUP_OUT[0];
            e[n] = CONFIG_PIN_GROUP_OUT[5];
            step(1);
        end
        chk("qtr", {4'h0, q[7:4] ^ q[3:0], q[1:0] ^ q[3:2]},
            10'h003);
        chk("eth", {6'h00, e[7:4] ^ e[3:0]}, 10'h00F);
        $display("clocks done");
    endtask
    initial begin
        step(5);
        RESET = 0;
        t_defaults();
        t_options();
        t_tx();
        t_serial();
        t_wake();
        t_clocks();
        summarize();
    end
endmodule
